// >>> core/clocked_serial_channel.sv
`timescale 1ns/1ps
`include "clocked_serial_defines.svh"
// Notes on behaviour
// - Mode bit: 0 asynchronous, 1 clocked
// - Prescale code scales bit clock by 4^n
// - Divisor sets bit rate
// - Control bit 7 gates tx empty request
// - Control bit 6 gates rx full, error
// - Control bit 5 enables transmitter
// - Control bit 4 enables receiver
// - Control bit 2 gates tx end request
// - Clock source, clocked mode only: 0X internal out, 1X external
// - Tx empty set on disable or load
// - Tx empty cleared by armed write, DMA
// - Rx full set when byte reaches buffer
// - Rx full cleared by armed write, DMA
// - Receiver disable keeps rx full
// - Reception while full: overrun, byte lost
// - Overrun set on overrun, armed write clears
// - Writing one to flags does nothing
// - Tx end set on disable or drained
// - Tx end cleared with tx empty
// - Smart card select switches operating mode
module clocked_serial_channel (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Register bus
   input wire clocked_serial_pkg::apb_req_t apbReq,
   output clocked_serial_pkg::apb_rsp_t apbRsp,
   // Serial pins
   input wire clocked_serial_pkg::pins_in_t pinsIn,
   output clocked_serial_pkg::pins_out_t pinsOut,
   // Transfer controller side
   input wire clocked_serial_pkg::dma_in_t dmaIn,
   output clocked_serial_pkg::req_out_t reqOut
);
   import clocked_serial_pkg::*;

   localparam chan_state_t STATE_RST = '{
      mode: `MODE_RST,
      divisor: `DIVISOR_RST,
      ctrl: `CONTROL_RST,
      smart_card_select: `SMART_RST,
      tx_empty_flag: `TX_EMPTY_FLAG_RST,
      tx_end_flag: `TX_END_FLAG_RST,
      txd: 1'b1,
      sckOut: 1'b1,
      sckPrev: 1'b1,
      txSt: TX_IDLE,
      rxSt: RX_IDLE,
      default: '0
   };

   chan_state_t s;
   chan_state_t next_s;

   logic setup;
   logic access;
   logic wrAccess;
   logic hitMode;
   logic hitDivisor;
   logic hitControl;
   logic hitTxData;
   logic hitStatus;
   logic hitRxData;
   logic hitSmart;
   logic mapped;
   logic [7:0] rdValue;
   logic syncMode;
   logic extClk;
   logic txEnable;
   logic rxEnable;
   logic txTick;
   logic rxTick;
   logic fallEv;
   logic riseEv;
   logic txReqOn;
   logic rxReqOn;
   logic txRestart;
   logic rxRestart;
   logic rxDone;
   logic [7:0] rxByte;

   function automatic logic regHit(input logic [31:0] addr, input logic [23:0] idx);
      return addr == {6'h00, idx, 2'b00};
   endfunction

   assign setup = apbReq.psel & ~apbReq.penable;
   assign access = apbReq.psel & apbReq.penable;
   assign wrAccess = access & apbReq.pwrite;
   assign hitMode = regHit(apbReq.paddr, `IDX_MODE);
   assign hitDivisor = regHit(apbReq.paddr, `IDX_DIVISOR);
   assign hitControl = regHit(apbReq.paddr, `IDX_CONTROL);
   assign hitTxData = regHit(apbReq.paddr, `IDX_TXDATA);
   assign hitStatus = regHit(apbReq.paddr, `IDX_STATUS);
   assign hitRxData = regHit(apbReq.paddr, `IDX_RXDATA);
   assign hitSmart = regHit(apbReq.paddr, `IDX_SMART);
   assign mapped = hitMode | hitDivisor | hitControl | hitTxData | hitStatus | hitRxData | hitSmart;

   // Smart card mode reuses the start-stop framing
   assign syncMode = s.mode[`MODE_SYNC_BIT] & ~s.smart_card_select;
   assign extClk = s.ctrl[`CTRL_CLOCK_SOURCE_SELECT_HI_BIT];
   assign txEnable = s.ctrl[`CTRL_TE_BIT];
   assign rxEnable = s.ctrl[`CTRL_RE_BIT];

   // Shift events from either our own divider or the peer's clock
   assign fallEv = extClk ? (s.sckPrev & ~pinsIn.sckIn) : (txTick & s.sckOut);
   assign riseEv = extClk ? (~s.sckPrev & pinsIn.sckIn) : (txTick & ~s.sckOut);

   assign txReqOn = s.tx_empty_flag & s.ctrl[`CTRL_TIE_BIT];
   assign rxReqOn = s.rx_full_flag & s.ctrl[`CTRL_RIE_BIT];

   bit_rate_gen txGen (
      .clk(clk),
      .srst(srst),
      .restart(txRestart),
      .prescale(s.mode[`MODE_PRESCALE_LSB +: 2]),
      .divisor(s.divisor),
      .tick(txTick)
   );

   bit_rate_gen rxGen (
      .clk(clk),
      .srst(srst),
      .restart(rxRestart),
      .prescale(s.mode[`MODE_PRESCALE_LSB +: 2]),
      .divisor(s.divisor),
      .tick(rxTick)
   );

   always_comb begin
      rdValue = 8'h00;
      if (hitMode) begin
         rdValue = s.mode;
      end else if (hitDivisor) begin
         rdValue = s.divisor;
      end else if (hitControl) begin
         rdValue = s.ctrl;
      end else if (hitTxData) begin
         rdValue = s.txBuf;
      end else if (hitStatus) begin
         rdValue[`ST_TX_EMPTY_FLAG_BIT] = s.tx_empty_flag;
         rdValue[`ST_RX_FULL_FLAG_BIT] = s.rx_full_flag;
         rdValue[`ST_OVERRUN_FLAG_BIT] = s.overrun_flag;
         rdValue[`ST_TX_END_FLAG_BIT] = s.tx_end_flag;
      end else if (hitRxData) begin
         rdValue = s.rxBuf;
      end else if (hitSmart) begin
         rdValue[`SMART_SEL_BIT] = s.smart_card_select;
      end
   end

   always_comb begin
      next_s = s;
      txRestart = 1'b0;
      rxRestart = 1'b0;
      rxDone = 1'b0;
      rxByte = s.rxSh;
      next_s.sckPrev = pinsIn.sckIn;

      // Read data latched in setup so the access phase needs no wait
      if (setup && !apbReq.pwrite) begin
         next_s.prdata = {24'h00_0000, rdValue};
      end
      // A flag only counts as read when the read completes
      if (access && !apbReq.pwrite && hitStatus) begin
         next_s.armTdre = s.armTdre | s.prdata[`ST_TX_EMPTY_FLAG_BIT];
         next_s.armRdrf = s.armRdrf | s.prdata[`ST_RX_FULL_FLAG_BIT];
         next_s.armOrer = s.armOrer | s.prdata[`ST_OVERRUN_FLAG_BIT];
      end

      if (wrAccess) begin
         if (hitMode) begin
            next_s.mode = apbReq.pwdata[7:0];
         end
         if (hitDivisor) begin
            next_s.divisor = apbReq.pwdata[7:0];
         end
         if (hitControl) begin
            next_s.ctrl = apbReq.pwdata[7:0];
         end
         if (hitTxData) begin
            next_s.txBuf = apbReq.pwdata[7:0];
         end
         if (hitSmart) begin
            next_s.smart_card_select = apbReq.pwdata[`SMART_SEL_BIT];
         end
         if (hitStatus) begin
            if (!apbReq.pwdata[`ST_TX_EMPTY_FLAG_BIT] && s.armTdre) begin
               next_s.tx_empty_flag = 1'b0;
               next_s.tx_end_flag = 1'b0;
               next_s.armTdre = 1'b0;
            end
            if (!apbReq.pwdata[`ST_RX_FULL_FLAG_BIT] && s.armRdrf) begin
               next_s.rx_full_flag = 1'b0;
               next_s.armRdrf = 1'b0;
            end
            if (!apbReq.pwdata[`ST_OVERRUN_FLAG_BIT] && s.armOrer) begin
               next_s.overrun_flag = 1'b0;
               next_s.armOrer = 1'b0;
            end
         end
      end

      // Controller services a raised request
      if (dmaIn.txWrite && txReqOn) begin
         next_s.txBuf = dmaIn.txData;
         next_s.tx_empty_flag = 1'b0;
         next_s.tx_end_flag = 1'b0;
         next_s.armTdre = 1'b0;
      end
      if (dmaIn.rxRead && rxReqOn) begin
         next_s.rx_full_flag = 1'b0;
         next_s.armRdrf = 1'b0;
      end

      // Transmit and clocked receive engine
      unique case (s.txSt)
         TX_IDLE: begin
            if (txEnable && !s.tx_empty_flag) begin
               next_s.txSt = TX_RUN;
               next_s.txSh = s.txBuf;
               next_s.tx_empty_flag = 1'b1;
               next_s.txBit = 4'h0;
               next_s.txPhase = 1'b0;
               next_s.frameTx = 1'b1;
               next_s.frameRx = syncMode & rxEnable;
               next_s.txd = syncMode ? s.txBuf[0] : 1'b0;
               txRestart = 1'b1;
            end else if (syncMode && rxEnable && !txEnable && !s.overrun_flag) begin
               // Receive only keeps clocking until an overrun stops it
               next_s.txSt = TX_RUN;
               next_s.txBit = 4'h0;
               next_s.frameTx = 1'b0;
               next_s.frameRx = 1'b1;
               txRestart = 1'b1;
            end
         end
         TX_RUN: begin
            if (syncMode) begin
               if (!s.frameTx && !rxEnable) begin
                  next_s.txSt = TX_IDLE;
                  next_s.sckOut = 1'b1;
               end else begin
                  if (fallEv) begin
                     if (!extClk) begin
                        next_s.sckOut = 1'b0;
                     end
                     if (s.txBit != 4'h0 && s.frameTx) begin
                        next_s.txSh = s.txSh >> 1;
                        next_s.txd = s.txSh[1];
                     end
                  end
                  if (riseEv) begin
                     if (!extClk) begin
                        next_s.sckOut = 1'b1;
                     end
                     next_s.rxSh = {pinsIn.rxd, s.rxSh[7:1]};
                     if (s.txBit == `SYNC_LAST_BIT) begin
                        next_s.txSt = TX_IDLE;
                        if (s.frameTx && s.tx_empty_flag) begin
                           next_s.tx_end_flag = 1'b1;
                        end
                        rxDone = s.frameRx & rxEnable;
                        rxByte = {pinsIn.rxd, s.rxSh[7:1]};
                     end else begin
                        next_s.txBit = s.txBit + 4'h1;
                     end
                  end
               end
            end else if (txTick) begin
               // Start bit, eight data bits, stop bit; two ticks each
               next_s.txPhase = ~s.txPhase;
               if (s.txPhase) begin
                  if (s.txBit == `ASYNC_STOP_BIT) begin
                     next_s.txSt = TX_IDLE;
                     if (s.tx_empty_flag) begin
                        next_s.tx_end_flag = 1'b1;
                     end
                  end else begin
                     next_s.txBit = s.txBit + 4'h1;
                     next_s.txd = (s.txBit == `ASYNC_PRE_STOP) ? 1'b1 : s.txSh[0];
                     next_s.txSh = s.txSh >> 1;
                  end
               end
            end
         end
      endcase

      // Start-stop receiver, sampled mid-bit
      if (syncMode || !rxEnable) begin
         next_s.rxSt = RX_IDLE;
      end else begin
         unique case (s.rxSt)
            RX_IDLE: begin
               if (!pinsIn.rxd) begin
                  next_s.rxSt = RX_START;
                  rxRestart = 1'b1;
               end
            end
            RX_START: begin
               if (rxTick) begin
                  next_s.rxSt = pinsIn.rxd ? RX_IDLE : RX_DATA;
                  next_s.rxBit = 4'h0;
                  next_s.rxPhase = 1'b0;
               end
            end
            RX_DATA: begin
               if (rxTick) begin
                  next_s.rxPhase = ~s.rxPhase;
                  if (s.rxPhase) begin
                     next_s.rxSh = {pinsIn.rxd, s.rxSh[7:1]};
                     if (s.rxBit == `ASYNC_LAST_DATA) begin
                        next_s.rxSt = RX_STOP;
                     end else begin
                        next_s.rxBit = s.rxBit + 4'h1;
                     end
                  end
               end
            end
            RX_STOP: begin
               if (rxTick) begin
                  next_s.rxPhase = ~s.rxPhase;
                  if (s.rxPhase) begin
                     // A low stop bit is not a normal end and is dropped
                     next_s.rxSt = RX_IDLE;
                     rxDone = pinsIn.rxd;
                     rxByte = s.rxSh;
                  end
               end
            end
         endcase
      end

      // Completed byte; a still-full buffer keeps the old byte
      if (rxDone) begin
         if (next_s.rx_full_flag) begin
            next_s.overrun_flag = 1'b1;
         end else begin
            next_s.rxBuf = rxByte;
            next_s.rx_full_flag = 1'b1;
         end
      end

      // Disabling the transmitter wins over any clear in the same cycle
      if (wrAccess && hitControl && !apbReq.pwdata[`CTRL_TE_BIT]) begin
         next_s.tx_empty_flag = 1'b1;
         next_s.tx_end_flag = 1'b1;
         if (s.frameTx) begin
            next_s.txSt = TX_IDLE;
            next_s.frameTx = 1'b0;
            next_s.txd = 1'b1;
            next_s.sckOut = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s <= STATE_RST;
      end else begin
         s <= next_s;
      end
   end

   // Zero wait states: read data already latched in setup
   assign apbRsp.pready = 1'b1;
   assign apbRsp.pslverr = access & ~mapped;
   assign apbRsp.prdata = s.prdata;

   assign pinsOut.sckOut = s.sckOut;
   assign pinsOut.sckOe = syncMode & ~extClk;
   assign pinsOut.txd = s.txd;

   assign reqOut.txEmpty = txReqOn;
   assign reqOut.rxFull = rxReqOn;
   assign reqOut.rxError = s.overrun_flag & s.ctrl[`CTRL_RIE_BIT];
   assign reqOut.txEnd = s.tx_end_flag & s.ctrl[`CTRL_TX_DONE_IRQ_ENABLE_BIT];
   assign reqOut.rxData = s.rxBuf;
endmodule

// >>> include/clocked_serial_defines.svh
`ifndef CLOCKED_SERIAL_DEFINES_SVH
`define CLOCKED_SERIAL_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_MODE 24'hFF_FF80
`define IDX_DIVISOR 24'hFF_FF81
`define IDX_CONTROL 24'hFF_FF82
`define IDX_TXDATA 24'hFF_FF83
`define IDX_STATUS 24'hFF_FF84
`define IDX_RXDATA 24'hFF_FF85
`define IDX_SMART 24'hFF_FF86

// Mode register fields
`define MODE_SYNC_BIT 7
`define MODE_PRESCALE_LSB 0

// Control register fields
`define CTRL_TIE_BIT 7
`define CTRL_RIE_BIT 6
`define CTRL_TE_BIT 5
`define CTRL_RE_BIT 4
`define CTRL_TX_DONE_IRQ_ENABLE_BIT 2
`define CTRL_CLOCK_SOURCE_SELECT_HI_BIT 1
`define CTRL_CLOCK_SOURCE_SELECT_LO_BIT 0

// Status register fields
`define ST_TX_EMPTY_FLAG_BIT 7
`define ST_RX_FULL_FLAG_BIT 6
`define ST_OVERRUN_FLAG_BIT 5
`define ST_TX_END_FLAG_BIT 2

// Smart card register field
`define SMART_SEL_BIT 0

// Reset values
`define MODE_RST 8'h00
`define DIVISOR_RST 8'hFF
`define CONTROL_RST 8'h00
`define TX_EMPTY_FLAG_RST 1'b1
`define TX_END_FLAG_RST 1'b1
`define SMART_RST 1'b0

// Frame counts
`define SYNC_LAST_BIT 4'h7
`define ASYNC_LAST_DATA 4'h7
`define ASYNC_STOP_BIT 4'h9
`define ASYNC_PRE_STOP 4'h8

`endif

// >>> include/clocked_serial_pkg.sv
package clocked_serial_pkg;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;

   typedef struct packed {
      logic sckIn;
      logic rxd;
   } pins_in_t;

   typedef struct packed {
      logic sckOut;
      logic sckOe;
      logic txd;
   } pins_out_t;

   typedef struct packed {
      logic txWrite;
      logic [7:0] txData;
      logic rxRead;
   } dma_in_t;

   typedef struct packed {
      logic txEmpty;
      logic rxFull;
      logic rxError;
      logic txEnd;
      logic [7:0] rxData;
   } req_out_t;

   typedef enum logic {
      TX_IDLE = 1'b0,
      TX_RUN = 1'b1
   } tx_state_t;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } rx_state_t;

   typedef struct packed {
      logic [15:0] count;
      logic tick;
   } gen_state_t;

   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] divisor;
      logic [7:0] ctrl;
      logic smart_card_select;
      logic [7:0] txBuf;
      logic [7:0] rxBuf;
      logic tx_empty_flag;
      logic rx_full_flag;
      logic overrun_flag;
      logic tx_end_flag;
      logic armTdre;
      logic armRdrf;
      logic armOrer;
      logic [31:0] prdata;
      tx_state_t txSt;
      logic [7:0] txSh;
      logic [3:0] txBit;
      logic txPhase;
      logic frameTx;
      logic frameRx;
      logic txd;
      logic sckOut;
      logic sckPrev;
      rx_state_t rxSt;
      logic [7:0] rxSh;
      logic [3:0] rxBit;
      logic rxPhase;
   } chan_state_t;

endpackage

// >>> core/bit_rate_gen.sv
`timescale 1ns/1ps
module bit_rate_gen (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Rate setting
   input wire logic restart,
   input wire logic [1:0] prescale,
   input wire logic [7:0] divisor,
   // Half bit tick
   output logic tick
);
   import clocked_serial_pkg::*;

   gen_state_t s;
   gen_state_t next_s;
   logic [15:0] limit;

   // Half period of 2*(N+1)*4^n cycles, so one bit is clk/(4*(N+1)*4^n)
   function automatic logic [15:0] halfPeriod(input logic [1:0] pre, input logic [7:0] div);
      return (({8'h00, div} + 16'h0001) << {pre, 1'b1}) - 16'h0001;
   endfunction

   assign limit = halfPeriod(prescale, divisor);

   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (restart) begin
         next_s.count = 16'h0000;
      end else if (s.count >= limit) begin
         next_s.count = 16'h0000;
         next_s.tick = 1'b1;
      end else begin
         next_s.count = s.count + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick = s.tick;
endmodule

// >>> verification/clocked_serial_peer.sv
`timescale 1ns/1ps
module clocked_serial_peer #(
   parameter int HALF = 8
) (
   // Clock
   input wire logic clk,
   // Serial line
   input wire logic sckLine,
   input wire logic txd,
   output logic rxd,
   output logic peerSck,
   // Frame control
   input wire logic arm,
   input wire logic extGo,
   input wire logic [7:0] sendByte,
   output logic [7:0] gotByte
);
   logic sckPrev = 1'b1;
   logic dOut = 1'b1;
   logic sckDrv = 1'b1;
   logic [7:0] got = 8'h00;
   logic [7:0] sendSh = 8'h00;
   logic [3:0] rises = 4'h0;
   int cnt = 0;
   int halves = 0;
   assign rxd = dOut;
   assign peerSck = sckDrv;
   assign gotByte = got;
   always @(posedge clk) begin
      sckPrev <= sckLine;
      if (arm) begin
         dOut <= sendByte[0];
         sendSh <= sendByte >> 1;
         rises <= 4'h0;
      end else if (sckLine && !sckPrev) begin
         // Sample on rising clock, LSB first
         got <= {txd, got[7:1]};
         rises <= rises + 4'h1;
         // Data line goes back to idle high after the last bit
         if (rises == 4'h7) begin
            dOut <= 1'b1;
         end
      end else if (!sckLine && sckPrev && rises != 4'h0) begin
         // Change only after a fall, never near the device's sample
         dOut <= sendSh[0];
         sendSh <= sendSh >> 1;
      end
      // External clock: low first, ends high, stands still outside frames
      if (extGo) begin
         halves <= 16;
         cnt <= HALF;
      end else if (halves != 0) begin
         if (cnt == 1) begin
            sckDrv <= !sckDrv;
            halves <= halves - 1;
            cnt <= HALF;
         end else begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule

// >>> verification/clocked_serial_channel_chk.sv
`timescale 1ns/1ps
`include "clocked_serial_defines.svh"
module clocked_serial_channel_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Watched ports
   input wire clocked_serial_pkg::apb_req_t apbReq,
   input wire clocked_serial_pkg::apb_rsp_t apbRsp,
   input wire clocked_serial_pkg::pins_in_t pinsIn,
   input wire clocked_serial_pkg::pins_out_t pinsOut,
   input wire clocked_serial_pkg::dma_in_t dmaIn,
   input wire clocked_serial_pkg::req_out_t reqOut
);
   import clocked_serial_pkg::*;
   logic [7:0] mode;
   logic [7:0] div;
   logic [7:0] ctrl;
   logic sckPrev;
   logic [15:0] cnt;
   logic [17:0] halfExp;
   logic wr;
   logic stWr;
   // Shadow copies of the registers, taken at the completing edge
   assign wr = apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready;
   assign stWr = wr && apbReq.paddr == 32'(`IDX_STATUS) << 2;
   assign halfExp = (18'(div) + 18'h0_0001) << (2 * mode[1:0] + 1);
   always_ff @(posedge clk) begin
      if (srst) begin
         mode <= 8'h00;
         div <= 8'hFF;
         ctrl <= 8'h00;
         sckPrev <= 1'b1;
         cnt <= 16'h0000;
      end else begin
         if (wr && apbReq.paddr == 32'(`IDX_MODE) << 2) mode <= apbReq.pwdata[7:0];
         if (wr && apbReq.paddr == 32'(`IDX_DIVISOR) << 2) div <= apbReq.pwdata[7:0];
         if (wr && apbReq.paddr == 32'(`IDX_CONTROL) << 2) ctrl <= apbReq.pwdata[7:0];
         sckPrev <= pinsOut.sckOut;
         cnt <= (pinsOut.sckOut != sckPrev) ? 16'h0001 : cnt + 16'h0001;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence sckRise;
      pinsOut.sckOe && pinsOut.sckOut && !sckPrev;
   endsequence
   sequence txTake;
      dmaIn.txWrite && reqOut.txEmpty;
   endsequence
   sequence rxTake;
      dmaIn.rxRead && reqOut.rxFull;
   endsequence
   a_tx_req_gate: assert property (!ctrl[7] |-> !reqOut.txEmpty)
      else $error("tx empty request passed while masked");
   a_rx_req_gate: assert property (!ctrl[6] |-> !reqOut.rxFull && !reqOut.rxError)
      else $error("rx request passed while masked");
   a_end_req_gate: assert property (!ctrl[2] |-> !reqOut.txEnd)
      else $error("tx end request passed while masked");
   a_clock_pin_dir: assert property (pinsOut.sckOe == (mode[7] && !ctrl[1]))
      else $error("clock pin direction wrong");
   a_idle_txd_high: assert property (!ctrl[5] && !$past(ctrl[5]) |-> pinsOut.txd)
      else $error("txd moved with transmitter off");
   a_half_period: assert property (sckRise |-> cnt == halfExp)
      else $error("serial clock half period wrong");
   a_dma_tx_take: assert property (txTake |=> !reqOut.txEmpty)
      else $error("tx empty not cleared by transfer");
   a_dma_rx_take: assert property (rxTake |=> !reqOut.rxFull)
      else $error("rx full not cleared by transfer");
   a_overrun_cause: assert property ($rose(reqOut.rxError) && $past(ctrl[6]) |-> $past(reqOut.rxFull))
      else $error("overrun without full buffer");
   a_overrun_sticky: assert property ($fell(reqOut.rxError) && ctrl[6] && $past(ctrl[6]) |-> $past(stWr))
      else $error("overrun cleared without status write");
endmodule
bind clocked_serial_channel clocked_serial_channel_chk chk (
   .clk(clk),
   .srst(srst),
   .apbReq(apbReq),
   .apbRsp(apbRsp),
   .pinsIn(pinsIn),
   .pinsOut(pinsOut),
   .dmaIn(dmaIn),
   .reqOut(reqOut)
);

// >>> verification/clocked_serial_channel_bench.sv
`timescale 1ns/1ps
`include "clocked_serial_defines.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fails++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); end end
module clocked_serial_channel_bench;
   import clocked_serial_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   clocked_serial_pkg::apb_req_t apbReq = '0;
   clocked_serial_pkg::apb_rsp_t apbRsp;
   clocked_serial_pkg::pins_in_t pinsIn;
   clocked_serial_pkg::pins_out_t pinsOut;
   clocked_serial_pkg::dma_in_t dmaIn = '0;
   clocked_serial_pkg::req_out_t reqOut;
   logic arm = 1'b0;
   logic extGo = 1'b0;
   logic loop = 1'b0;
   logic [7:0] sendByte = 8'h00;
   logic rxd;
   logic peerSck;
   logic [7:0] gotByte;
   logic [7:0] rd;
   logic err;
   int fails = 0;
   int num_checks = 0;
   always #2.5 clk = ~clk;
   // Clock line: whoever has the pin drives it
   // Data line looped back from txd for start-stop frames
   assign pinsIn = {pinsOut.sckOe ? pinsOut.sckOut : peerSck, loop ? pinsOut.txd : rxd};
   clocked_serial_channel uut (.clk(clk), .srst(srst), .apbReq(apbReq), .apbRsp(apbRsp),
      .pinsIn(pinsIn), .pinsOut(pinsOut), .dmaIn(dmaIn), .reqOut(reqOut));
   clocked_serial_peer #(.HALF(8)) peer (.clk(clk), .sckLine(pinsIn.sckIn), .txd(pinsOut.txd), .rxd(rxd),
      .peerSck(peerSck), .arm(arm), .extGo(extGo), .sendByte(sendByte), .gotByte(gotByte));
   task automatic finish_test();
      if (fails == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [23:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {6'h00, idx, 2'b00}, pwdata: {24'h00_0000, wd}};
      @(posedge clk);
      apbReq.penable <= 1'b1;
      // Wait states allowed: loop until ready seen at an edge, up to 64 edges
      do begin
         @(posedge clk);
         n++;
      end while (apbRsp.pready !== 1'b1 && n < 64);
      if (n >= 64) fails++;
      rd = apbRsp.prdata[7:0];
      err = apbRsp.pslverr;
      apbReq <= '0;
   endtask
   task automatic chkRead(input logic [23:0] idx, input logic [7:0] exp);
      xfer(1'b0, idx, 8'h00);
      `CHK(rd, exp)
   endtask
   task automatic frame(input logic [7:0] tx, input logic [7:0] pb, input logic dma, input logic ext);
      int n;
      n = 0;
      @(posedge clk);
      arm <= 1'b1;
      sendByte <= pb;
      extGo <= ext;
      @(posedge clk);
      arm <= 1'b0;
      extGo <= 1'b0;
      if (dma) begin
         dmaIn <= '{txWrite: 1'b1, txData: tx, rxRead: 1'b0};
         @(posedge clk);
         dmaIn <= '0;
         #1 `CHK(reqOut.txEnd, 1'b0)
      end
      do begin
         @(posedge clk);
         #1 n++;
      end while (reqOut.txEnd !== 1'b1 && n < 4000);
      if (n >= 4000) fails++;
      repeat (2) @(posedge clk);
      #1;
   endtask
   initial begin
      #100000;
      fails++;
      finish_test();
   end
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      chkRead(`IDX_MODE, 8'h00);
      chkRead(`IDX_DIVISOR, 8'hFF);
      chkRead(`IDX_CONTROL, 8'h00);
      chkRead(`IDX_STATUS, 8'h84);
      chkRead(`IDX_SMART, 8'h00);
      xfer(1'b0, 24'hFF_FF8F, 8'h00);
      `CHK({err, rd}, 9'h100)
      xfer(1'b1, `IDX_SMART, 8'h01);
      chkRead(`IDX_SMART, 8'h01);
      xfer(1'b1, `IDX_SMART, 8'h00);
      xfer(1'b1, `IDX_STATUS, 8'hFF);
      chkRead(`IDX_STATUS, 8'h84);
      xfer(1'b1, `IDX_MODE, 8'h80);
      xfer(1'b1, `IDX_DIVISOR, 8'h1F);
      xfer(1'b1, `IDX_CONTROL, 8'hF4);
      chkRead(`IDX_CONTROL, 8'hF4);
      frame(8'hA5, 8'h3C, 1'b1, 1'b0);
      `CHK(gotByte, 8'hA5)
      `CHK(reqOut.rxData, 8'h3C)
      chkRead(`IDX_STATUS, 8'hC4);
      @(posedge clk);
      dmaIn <= '{txWrite: 1'b0, txData: 8'h00, rxRead: 1'b1};
      @(posedge clk);
      dmaIn <= '0;
      #1 `CHK(reqOut.rxFull, 1'b0)
      frame(8'h11, 8'h5A, 1'b1, 1'b0);
      frame(8'h22, 8'h77, 1'b1, 1'b0);
      `CHK(reqOut.rxError, 1'b1)
      `CHK(reqOut.rxData, 8'h5A)
      chkRead(`IDX_STATUS, 8'hE4);
      xfer(1'b1, `IDX_STATUS, 8'h84);
      chkRead(`IDX_STATUS, 8'h84);
      // External clock, software loads and clears the flag itself
      xfer(1'b1, `IDX_CONTROL, 8'h36);
      #1 `CHK({reqOut.txEmpty, pinsOut.sckOe}, 2'b00)
      xfer(1'b1, `IDX_TXDATA, 8'hC3);
      xfer(1'b1, `IDX_STATUS, 8'h00);
      chkRead(`IDX_STATUS, 8'h80);
      frame(8'h00, 8'h96, 1'b0, 1'b1);
      `CHK(gotByte, 8'hC3)
      `CHK(reqOut.rxData, 8'h96)
      chkRead(`IDX_STATUS, 8'hC4);
      xfer(1'b1, `IDX_STATUS, 8'h40);
      chkRead(`IDX_STATUS, 8'hC0);
      xfer(1'b1, `IDX_CONTROL, 8'h00);
      chkRead(`IDX_STATUS, 8'hC4);
      // Start-stop framing, own txd looped back to rxd
      loop <= 1'b1;
      xfer(1'b1, `IDX_MODE, 8'h00);
      xfer(1'b1, `IDX_STATUS, 8'h80);
      xfer(1'b1, `IDX_TXDATA, 8'h5C);
      xfer(1'b1, `IDX_CONTROL, 8'h34);
      xfer(1'b1, `IDX_STATUS, 8'h00);
      frame(8'h00, 8'h00, 1'b0, 1'b0);
      `CHK({pinsOut.sckOe, reqOut.rxData}, 9'h05C)
      chkRead(`IDX_STATUS, 8'hC4);
      finish_test();
   end
endmodule
